// ---- cfd_regs.svh ----
// register indices, field positions, reset values and decode constants for the configuration decoder
// Overview of operation
// R1: watchdog postscale field bits 3..1 gives divide ratio 2^field, 1:1 up to 1:128.
// R2: watchdog fuse enable one runs watchdog always; zero defers to software enable.
// R3: unimplemented configuration bit positions always read back as zero.
// R4: brown-out level bits 3..2 select 2.5V, 2.7V, 4.2V or 4.5V trip.
// R5: brown-out enable bit 1 turns brown-out reset generation on or off.
// R6: power-up timer enable bit 0 is active low: one disables the timer.
// R7: brown-out reset enabled forces the power-up timer on regardless of its bit.
// R8: channel-2 pin select zero routes capture/compare to port B bit 3, one elsewhere.
// R9: configuration bits read one when unprogrammed; programming only clears bits.
// R10: eight one-byte user ID locations at indices 0x200000 through 0x200007.
// R11: ID locations read back true contents even when code protection is on.
// R12: programmer should write ID upper nibble as ones, data in lower nibble.
// R13: an executed ID byte with upper nibble all ones behaves as no-operation.
// R14: watchdog, brown-out and pin select bytes sit at 300003h, 300002h, 300005h.
// R15: stack-fault enable bit 0 resets on stack full or underflow when one.
// R16: decoded controls stay stable after reset and feed their units continuously.
`ifndef CFD_REGS_SVH
`define CFD_REGS_SVH

`define CFD_IDX_BOR 32'h0030_0002
`define CFD_IDX_WDT 32'h0030_0003
`define CFD_IDX_CCP 32'h0030_0005
`define CFD_IDX_STK 32'h0030_0006
`define CFD_IDX_ID_FIRST 32'h0020_0000
`define CFD_ID_COUNT 8
`define CFD_ID_AW 3

`define CFD_UNPROG 8'hFF
`define CFD_MASK_WDT 8'h0F
`define CFD_MASK_BOR 8'h0F
`define CFD_MASK_CCP 8'h01
`define CFD_MASK_STK 8'h03

`define CFD_WDT_PS_MSB 3
`define CFD_WDT_PS_LSB 1
`define CFD_WDT_EN_BIT 0
`define CFD_BOR_LVL_MSB 3
`define CFD_BOR_LVL_LSB 2
`define CFD_BOR_EN_BIT 1
`define CFD_POWERUP_TIMER_N_BIT 0
`define CFD_CCP_SEL_BIT 0
`define CFD_STK_EN_BIT 0

`define CFD_RATIO_ONE 8'h01
`define CFD_BOR_MV_00 16'h1194
`define CFD_BOR_MV_01 16'h1068
`define CFD_BOR_MV_10 16'h0A8C
`define CFD_BOR_MV_11 16'h09C4
`define CFD_NOP_NIBBLE 4'hF

`endif

// ---- cfd_pkg.sv ----
// types shared by the configuration decoder files
package cfd_pkg;

    typedef enum logic [5:0] {
        CFD_SEL_NONE = 6'h01,
        CFD_SEL_BOR = 6'h02,
        CFD_SEL_WDT = 6'h04,
        CFD_SEL_CCP = 6'h08,
        CFD_SEL_STK = 6'h10,
        CFD_SEL_ID = 6'h20
    } cfd_sel_t;

    typedef struct packed {
        logic [7:0] wdt_cfg;
        logic [7:0] bor_cfg;
        logic [7:0] ccp_cfg;
        logic [7:0] stk_cfg;
        logic dp_valid;
        logic dp_write;
        cfd_sel_t dp_sel;
        logic [2:0] dp_idx;
        logic [31:0] rdata;
        logic ccp_in;
        logic pb3_out;
        logic pb3_oe_n;
        logic alt_out;
        logic alt_oe_n;
        logic stk_reset;
    } cfd_state_t;

endpackage

// ---- cfd_id_mem.sv ----
// user ID byte store with clear-only programming and two registered read ports
module cfd_id_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data,
    input wire logic [AW-1:0] fetch_addr,
    output logic [WIDTH-1:0] fetch_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
        logic [WIDTH-1:0] fd;
    } cfd_mem_state_t;

    cfd_mem_state_t s_reg;
    cfd_mem_state_t s_next;

    always_comb begin
        s_next = s_reg;
        // programming can only clear bits
        if (wr_en) begin
            s_next.mem[wr_addr] = s_reg.mem[wr_addr] & wr_data; // R9
        end
        // reads see a write in flight; no scrambling on any path
        s_next.rd = s_next.mem[rd_addr]; // R11
        s_next.fd = s_next.mem[fetch_addr];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data = s_reg.rd;
    assign fetch_data = s_reg.fd;

endmodule

// ---- cfd_config_decode.sv ----
// configuration byte decoder with ahb-lite access to fuse bytes and user ID locations
`include "cfd_regs.svh"

module cfd_config_decode (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic watchdog_soft_enable,
    output logic [7:0] watchdog_postscale_ratio,
    output logic [2:0] watchdog_postscale_sel,
    output logic watchdog_timer_run,
    output logic [1:0] brownout_level_sel,
    output logic [15:0] brownout_trip_level,
    output logic brownout_reset_enable,
    output logic powerup_timer_run,
    input wire logic capture_ch2_out,
    input wire logic capture_ch2_drive,
    output logic capture_ch2_in,
    output logic capture_ch2_pin_sel,
    input wire logic portb_bit3_in,
    output logic portb_bit3_out,
    output logic portb_bit3_oe_n,
    input wire logic alt_pin_in,
    output logic alt_pin_out,
    output logic alt_pin_oe_n,
    input wire logic stack_full,
    input wire logic stack_underflow,
    output logic stack_fault_reset_enable,
    output logic stack_fault_reset,
    input wire logic [2:0] id_fetch_addr,
    output logic [7:0] id_fetch_opcode,
    output logic id_fetch_nop
);
    import cfd_pkg::*;

    cfd_state_t s_reg;
    cfd_state_t s_next;

    localparam cfd_state_t CFD_RST = '{
        wdt_cfg: `CFD_UNPROG,
        bor_cfg: `CFD_UNPROG,
        ccp_cfg: `CFD_UNPROG,
        stk_cfg: `CFD_UNPROG,
        dp_valid: 1'b0,
        dp_write: 1'b0,
        dp_sel: CFD_SEL_NONE,
        dp_idx: 3'h0,
        rdata: 32'h0000_0000,
        ccp_in: 1'b0,
        pb3_out: 1'b0,
        pb3_oe_n: 1'b1,
        alt_out: 1'b0,
        alt_oe_n: 1'b1,
        stk_reset: 1'b0
    };

    logic addr_take;
    cfd_sel_t sel_a;
    logic id_wr_en;
    logic [7:0] id_rd_data;
    logic [7:0] wdt_rd;
    logic [7:0] bor_rd;
    logic [7:0] ccp_rd;
    logic [7:0] stk_rd;

    // address decode: registers sit at four times their index
    always_comb begin
        sel_a = CFD_SEL_NONE;
        if (haddr[1:0] == 2'h0) begin
            if (haddr[31:2] == 30'(`CFD_IDX_BOR)) begin // R14
                sel_a = CFD_SEL_BOR;
            end else if (haddr[31:2] == 30'(`CFD_IDX_WDT)) begin // R14
                sel_a = CFD_SEL_WDT;
            end else if (haddr[31:2] == 30'(`CFD_IDX_CCP)) begin // R14
                sel_a = CFD_SEL_CCP;
            end else if (haddr[31:2] == 30'(`CFD_IDX_STK)) begin
                sel_a = CFD_SEL_STK;
            end else if (haddr[31:5] == 27'(`CFD_IDX_ID_FIRST >> `CFD_ID_AW)) begin // R10
                sel_a = CFD_SEL_ID;
            end
        end
    end

    assign addr_take = hsel && hready && htrans[1];
    assign id_wr_en = s_reg.dp_valid && s_reg.dp_write && (s_reg.dp_sel == CFD_SEL_ID);

    // unimplemented bits are masked on every read path
    assign wdt_rd = s_next.wdt_cfg & `CFD_MASK_WDT; // R3
    assign bor_rd = s_next.bor_cfg & `CFD_MASK_BOR; // R3
    assign ccp_rd = s_next.ccp_cfg & `CFD_MASK_CCP; // R3
    assign stk_rd = s_next.stk_cfg & `CFD_MASK_STK; // R3

    always_comb begin
        s_next = s_reg;
        // data phase of a write: fuse bytes only lose ones
        if (s_reg.dp_valid && s_reg.dp_write) begin
            unique case (s_reg.dp_sel)
                CFD_SEL_BOR: s_next.bor_cfg = s_reg.bor_cfg & hwdata[7:0]; // R9
                CFD_SEL_WDT: s_next.wdt_cfg = s_reg.wdt_cfg & hwdata[7:0]; // R9
                CFD_SEL_CCP: s_next.ccp_cfg = s_reg.ccp_cfg & hwdata[7:0]; // R9
                CFD_SEL_STK: s_next.stk_cfg = s_reg.stk_cfg & hwdata[7:0]; // R9
                CFD_SEL_ID: begin
                end
                CFD_SEL_NONE: begin
                end
            endcase
        end
        s_next.dp_valid = addr_take;
        s_next.dp_write = addr_take && hwrite;
        s_next.dp_sel = addr_take ? sel_a : CFD_SEL_NONE;
        s_next.dp_idx = haddr[4:2];
        s_next.rdata = 32'h0000_0000;
        if (addr_take && !hwrite) begin
            unique case (sel_a)
                CFD_SEL_BOR: s_next.rdata = {24'h00_0000, bor_rd};
                CFD_SEL_WDT: s_next.rdata = {24'h00_0000, wdt_rd};
                CFD_SEL_CCP: s_next.rdata = {24'h00_0000, ccp_rd};
                CFD_SEL_STK: s_next.rdata = {24'h00_0000, stk_rd};
                CFD_SEL_ID: begin
                end
                CFD_SEL_NONE: begin
                end
            endcase
        end
        // capture/compare channel 2 pin routing
        if (s_reg.ccp_cfg[`CFD_CCP_SEL_BIT]) begin // R8
            s_next.ccp_in = alt_pin_in;
            s_next.alt_out = capture_ch2_out;
            s_next.alt_oe_n = !capture_ch2_drive;
            s_next.pb3_out = 1'b0;
            s_next.pb3_oe_n = 1'b1;
        end else begin // R8
            s_next.ccp_in = portb_bit3_in;
            s_next.pb3_out = capture_ch2_out;
            s_next.pb3_oe_n = !capture_ch2_drive;
            s_next.alt_out = 1'b0;
            s_next.alt_oe_n = 1'b1;
        end
        s_next.stk_reset = s_reg.stk_cfg[`CFD_STK_EN_BIT] && (stack_full || stack_underflow); // R15
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= CFD_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    cfd_id_mem #(
        .WIDTH(8),
        .DEPTH(`CFD_ID_COUNT),
        .AW(`CFD_ID_AW)
    ) u_id_mem (
        .clk(hclk),
        .rst_n(hresetn),
        .wr_en(id_wr_en),
        .wr_addr(s_reg.dp_idx),
        .wr_data(hwdata[7:0]),
        .rd_addr(haddr[4:2]),
        .rd_data(id_rd_data),
        .fetch_addr(id_fetch_addr),
        .fetch_data(id_fetch_opcode)
    );

    // zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = (s_reg.dp_sel == CFD_SEL_ID) ? {24'h00_0000, id_rd_data} : s_reg.rdata; // R11

    // decoded controls other than watchdog_timer_run, which also ORs in watchdog_soft_enable, follow the fuse flops directly, so they never glitch
    assign watchdog_postscale_sel = s_reg.wdt_cfg[`CFD_WDT_PS_MSB:`CFD_WDT_PS_LSB];
    assign watchdog_postscale_ratio = `CFD_RATIO_ONE << watchdog_postscale_sel; // R1 R16
    assign watchdog_timer_run = s_reg.wdt_cfg[`CFD_WDT_EN_BIT] || watchdog_soft_enable; // R2
    assign brownout_level_sel = s_reg.bor_cfg[`CFD_BOR_LVL_MSB:`CFD_BOR_LVL_LSB];
    always_comb begin
        unique case (brownout_level_sel) // R4
            2'h3: brownout_trip_level = `CFD_BOR_MV_11;
            2'h2: brownout_trip_level = `CFD_BOR_MV_10;
            2'h1: brownout_trip_level = `CFD_BOR_MV_01;
            2'h0: brownout_trip_level = `CFD_BOR_MV_00;
        endcase
    end
    assign brownout_reset_enable = s_reg.bor_cfg[`CFD_BOR_EN_BIT]; // R5
    assign powerup_timer_run = !s_reg.bor_cfg[`CFD_POWERUP_TIMER_N_BIT] || brownout_reset_enable; // R6 R7
    assign capture_ch2_pin_sel = s_reg.ccp_cfg[`CFD_CCP_SEL_BIT];
    assign capture_ch2_in = s_reg.ccp_in;
    assign portb_bit3_out = s_reg.pb3_out;
    assign portb_bit3_oe_n = s_reg.pb3_oe_n;
    assign alt_pin_out = s_reg.alt_out;
    assign alt_pin_oe_n = s_reg.alt_oe_n;
    assign stack_fault_reset_enable = s_reg.stk_cfg[`CFD_STK_EN_BIT];
    assign stack_fault_reset = s_reg.stk_reset;
    assign id_fetch_nop = (id_fetch_opcode[7:4] == `CFD_NOP_NIBBLE); // R13

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    postscale_ratio_a: assert property ( // R1
        $countones(watchdog_postscale_ratio) == 1 &&
        watchdog_postscale_ratio == (`CFD_RATIO_ONE << s_reg.wdt_cfg[3:1]))
        else $error("postscale ratio does not match select field");

    watchdog_force_a: assert property ( // R2
        s_reg.wdt_cfg[`CFD_WDT_EN_BIT] |-> watchdog_timer_run)
        else $error("watchdog stopped while fuse enable set");

    watchdog_soft_a: assert property ( // R2
        !s_reg.wdt_cfg[`CFD_WDT_EN_BIT] |-> watchdog_timer_run == watchdog_soft_enable)
        else $error("watchdog does not follow software enable");

    reserved_read_a: assert property ( // R3
        addr_take && !hwrite && sel_a != CFD_SEL_ID |=> hrdata[31:4] == 28'h000_0000)
        else $error("reserved bits read nonzero");

    trip_level_a: assert property ( // R4
        brownout_level_sel == 2'h3 |-> brownout_trip_level == 16'h09C4)
        else $error("lowest trip code not decoded");

    powerup_timer_force_a: assert property ( // R7
        brownout_reset_enable |-> powerup_timer_run)
        else $error("power-up timer off while brown-out enabled");

    powerup_timer_low_a: assert property ( // R6
        !brownout_reset_enable |-> powerup_timer_run == !s_reg.bor_cfg[0])
        else $error("power-up timer enable not active low");

    fuse_clear_a: assert property ( // R9
        ((s_reg.wdt_cfg & ~$past(s_reg.wdt_cfg)) == 8'h00) && ((s_reg.bor_cfg & ~$past(s_reg.bor_cfg)) == 8'h00))
        else $error("fuse bit went from zero to one");

    pin_route_a: assert property ( // R8
        !capture_ch2_pin_sel ##1 !capture_ch2_pin_sel |-> portb_bit3_out == $past(capture_ch2_out) && alt_pin_oe_n)
        else $error("channel 2 not routed to port B bit 3");

    stack_reset_a: assert property ( // R15
        stack_fault_reset_enable && (stack_full || stack_underflow) |=> stack_fault_reset)
        else $error("stack fault did not raise reset");

    ahb_okay_a: assert property (
        hreadyout && !hresp)
        else $error("slave must answer zero-wait OKAY");

    wdt_write_c: cover property (addr_take && hwrite && sel_a == CFD_SEL_WDT ##1 s_reg.dp_write);
    id_read_c: cover property (addr_take && !hwrite && sel_a == CFD_SEL_ID);
    bor_off_c: cover property (!brownout_reset_enable && powerup_timer_run);
    stack_reset_c: cover property (stack_fault_reset);

endmodule

// ---- cfd_prog_model.sv ----
// ahb-lite programmer model that writes and reads the fuse and ID bytes
module cfd_prog_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // bounded wait for hready; running out ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 16);
        if (hready !== 1'b1) begin
            tb.err_total++;
            tb.wrap_up();
        end
    endtask
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        // released lines do not keep the last value
        hsel <= 1'b0;
        haddr <= ~a;
        hwdata <= ~d;
        // let one edge pass so a following call never reassigns in this time step
        @(posedge hclk);
    endtask
    task automatic id_prog(input logic [2:0] n, input logic [3:0] nib);
        logic [31:0] r;
        xfer({27'h0040000, n, 2'h0}, 1'b1, {24'h0, 4'hF, nib}, r);
    endtask
endmodule

// ---- tb.sv ----
// self-checking testbench for the configuration byte decoder
`include "cfd_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, watchdog_soft_enable = 1'b0;
    logic capture_ch2_out = 1'b0, capture_ch2_drive = 1'b0, portb_bit3_in = 1'b0, alt_pin_in = 1'b0;
    logic stack_full = 1'b0, stack_underflow = 1'b0;
    logic [2:0] id_fetch_addr = 3'h0;
    logic hsel, hwrite, hreadyout, hresp, watchdog_timer_run, brownout_reset_enable, powerup_timer_run;
    logic capture_ch2_in, capture_ch2_pin_sel, portb_bit3_out, portb_bit3_oe_n, alt_pin_out, alt_pin_oe_n;
    logic stack_fault_reset_enable, stack_fault_reset, id_fetch_nop;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, brownout_level_sel;
    logic [2:0] hsize, watchdog_postscale_sel;
    logic [7:0] watchdog_postscale_ratio, id_fetch_opcode;
    logic [15:0] brownout_trip_level;
    logic [15:0] mv [4] = '{`CFD_BOR_MV_00, `CFD_BOR_MV_01, `CFD_BOR_MV_10, `CFD_BOR_MV_11};
    localparam logic [31:0] a_bor = `CFD_IDX_BOR << 2;
    localparam logic [31:0] a_wdt = `CFD_IDX_WDT << 2;
    localparam logic [31:0] a_ccp = `CFD_IDX_CCP << 2;
    localparam logic [31:0] a_stk = `CFD_IDX_STK << 2;
    localparam logic [31:0] a_id = `CFD_IDX_ID_FIRST << 2;
    int err_total = 0;
    int samples_checked = 0;
    always #2 hclk = ~hclk;
    cfd_config_decode u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .watchdog_soft_enable, .watchdog_postscale_ratio,
        .watchdog_postscale_sel, .watchdog_timer_run, .brownout_level_sel, .brownout_trip_level,
        .brownout_reset_enable, .powerup_timer_run, .capture_ch2_out, .capture_ch2_drive, .capture_ch2_in,
        .capture_ch2_pin_sel, .portb_bit3_in, .portb_bit3_out, .portb_bit3_oe_n, .alt_pin_in, .alt_pin_out,
        .alt_pin_oe_n, .stack_full, .stack_underflow, .stack_fault_reset_enable, .stack_fault_reset,
        .id_fetch_addr, .id_fetch_opcode, .id_fetch_nop);
    cfd_prog_model u_prog (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_prog.xfer(a, 1'b1, d, r);
        #1;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        u_prog.xfer(a, 1'b0, 32'h0, r);
        chk(r, e);
    endtask
    task automatic t_reset();
        do_reset();
        chk(watchdog_postscale_ratio, 8'h80);
        chk(brownout_trip_level, `CFD_BOR_MV_11);
        chk({watchdog_timer_run, brownout_reset_enable, powerup_timer_run, capture_ch2_pin_sel}, 4'hF);
        chk({stack_fault_reset_enable, stack_fault_reset, hresp}, 3'h4);
        rdc(a_wdt, 32'h0F);
        rdc(a_bor, 32'h0F);
        rdc(a_ccp, 32'h01);
        rdc(a_stk, 32'h03);
        wr(32'h00C00010, 32'h0);
        rdc(32'h00C00010, 32'h0);
    endtask
    task automatic t_wdt();
        for (int s = 0; s < 8; s++) begin
            do_reset();
            wr(a_wdt, {28'hFFFFFFF, s[2:0], 1'b1});
            chk(watchdog_postscale_ratio, 8'h01 << s);
            chk(watchdog_postscale_sel, s[2:0]);
            chk(watchdog_timer_run, 1'b1);
            rdc(a_wdt, {28'h0, s[2:0], 1'b1});
        end
        wr(a_wdt, 32'h0);
        for (int e = 0; e < 2; e++) begin
            @(posedge hclk);
            watchdog_soft_enable <= e[0];
            #1;
            chk(watchdog_timer_run, e[0]);
        end
    endtask
    task automatic t_bor();
        for (int i = 0; i < 4; i++) begin
            do_reset();
            wr(a_bor, {28'h0, i[1:0], i[0], i[1]});
            chk(brownout_level_sel, i[1:0]);
            chk(brownout_trip_level, mv[i]);
            chk(brownout_reset_enable, i[0]);
            chk(powerup_timer_run, !i[1] | i[0]);
        end
        wr(a_bor, 32'h0);
        wr(a_bor, 32'hF);
        rdc(a_bor, 32'h0);
    endtask
    task automatic t_pin();
        for (int k = 1; k >= 0; k--) begin
            if (k == 0) wr(a_ccp, 32'h0);
            chk(capture_ch2_pin_sel, k[0]);
            @(posedge hclk);
            capture_ch2_out <= 1'b1;
            capture_ch2_drive <= 1'b1;
            portb_bit3_in <= ~k[0];
            alt_pin_in <= k[0];
            @(posedge hclk);
            #1;
            chk({alt_pin_oe_n, portb_bit3_oe_n}, k ? 2'h1 : 2'h2);
            chk(k ? alt_pin_out : portb_bit3_out, 1'b1);
            chk(capture_ch2_in, 1'b1);
        end
    endtask
    task automatic t_stk();
        for (int k = 1; k >= 0; k--) begin
            if (k == 0) wr(a_stk, 32'h2);
            @(posedge hclk);
            stack_full <= 1'b1;
            @(posedge hclk);
            stack_full <= 1'b0;
            stack_underflow <= 1'b1;
            #1;
            chk(stack_fault_reset, k[0]);
            @(posedge hclk);
            stack_underflow <= 1'b0;
            #1;
            chk(stack_fault_reset, k[0]);
            @(posedge hclk);
            #1;
            chk(stack_fault_reset, 1'b0);
        end
    endtask
    task automatic t_id();
        for (int n = 0; n < 8; n++) u_prog.id_prog(n[2:0], n[3:0] ^ 4'hA);
        for (int n = 0; n < 8; n++) begin
            rdc(a_id + 4 * n, {24'h0, 4'hF, n[3:0] ^ 4'hA});
            @(posedge hclk);
            id_fetch_addr <= n[2:0];
            @(posedge hclk);
            #1;
            chk({id_fetch_nop, id_fetch_opcode}, {5'h1F, n[3:0] ^ 4'hA});
        end
        rdc(a_id + 32'h20, 32'h0);
        wr(a_id + 32'h1C, 32'h35);
        @(posedge hclk);
        #1;
        chk({id_fetch_nop, id_fetch_opcode}, 9'h035);
        chk(watchdog_postscale_ratio, 8'h80);
    endtask
    initial begin
        t_reset();
        t_wdt();
        t_bor();
        t_pin();
        t_stk();
        t_id();
        wrap_up();
    end
endmodule
